// >>> rtl/operand_address_generation.sv
// Operand effective-address generator with dual prefetch and modulo buffers
// Summary of operation
// (R1) Move and accumulator operands can use register indirect plus a register offset.
// (R2) Source and destination modes may differ but share one 4-bit offset register field.
// (R3) Move and accumulator operands also allow literal offset and 8- or 16-bit literals.
// (R4) Dual prefetch pointers are only working registers eight to eleven.
// (R5) Pointers eight and nine go to the X unit, ten and eleven to the Y unit.
// (R6) Software keeps prefetch addresses inside the space of their unit.
// (R7) Indexed prefetch is only allowed on pointer nine in X and pointer eleven in Y.
// (R8) Prefetch offers plain indirect and post-modify by 2, 4 or 6.
// (R9) Branch literal is 16-bit signed and the interrupt hold literal 14-bit unsigned.
// (R10) Modulo addressing serves data and program space alike; the code applies it only to the X and Y prefetch pointers.
// (R11) One circular buffer lives in X space, one in Y space.
// (R12) Any working register may be the modulo pointer; frame and stack pointers are flagged; the code wraps only prefetch pointers eight to eleven.
// (R13) A buffer normally runs in one direction with its boundary restriction; the code checks both boundaries when start <= end, none otherwise.
// (R14) Power-of-two buffers may run both ways with both boundaries checked.
// (R15) A pointer update that crosses a boundary wraps to the other boundary.
module operand_address_generation
	import agu_pkg::*;
(
	input wire logic clk,
	input wire logic resetn,
	// Move and accumulator request
	input wire logic mov_valid,
	input wire logic [3:0] src_mode,
	input wire logic [3:0] dst_mode,
	input wire logic [REG_SEL_W-1:0] src_reg,
	input wire logic [REG_SEL_W-1:0] dst_reg,
	input wire logic [OFFSET_W-1:0] shared_offset_field,
	input wire logic [DATA_W-1:0] literal_value,
	input wire logic lit_is_word,
	input wire logic [DATA_W-1:0] src_ptr_val,
	input wire logic [DATA_W-1:0] dst_ptr_val,
	input wire logic [DATA_W-1:0] offset_reg_val,
	// Multiply-accumulate prefetch request
	input wire logic mac_valid,
	input wire logic [REG_SEL_W-1:0] x_sel,
	input wire logic [REG_SEL_W-1:0] y_sel,
	input wire logic [2:0] x_pf_mode,
	input wire logic [2:0] y_pf_mode,
	input wire logic [DATA_W-1:0] x_ptr_val,
	input wire logic [DATA_W-1:0] y_ptr_val,
	input wire logic [DATA_W-1:0] x_index_val,
	input wire logic [DATA_W-1:0] y_index_val,
	// Branch and interrupt hold literals
	input wire logic branch_instr,
	input wire logic interrupt_hold_instr,
	input wire logic [DATA_W-1:0] instr_literal,
	// Modulo configuration
	input wire logic x_mod_en,
	input wire logic y_mod_en,
	input wire logic x_mod_bidir,
	input wire logic y_mod_bidir,
	input wire logic [REG_SEL_W-1:0] x_mod_reg,
	input wire logic [REG_SEL_W-1:0] y_mod_reg,
	input wire logic [DATA_W-1:0] x_mod_start,
	input wire logic [DATA_W-1:0] x_mod_end,
	input wire logic [DATA_W-1:0] y_mod_start,
	input wire logic [DATA_W-1:0] y_mod_end,
	// Move results
	output logic mov_done,
	output logic [DATA_W-1:0] src_ea,
	output logic [DATA_W-1:0] dst_ea,
	output logic src_is_literal,
	output logic [DATA_W-1:0] src_ptr_upd,
	output logic [DATA_W-1:0] dst_ptr_upd,
	// Prefetch results
	output logic mac_done,
	output logic mac_error,
	output logic [DATA_W-1:0] x_rd_addr,
	output logic [DATA_W-1:0] y_rd_addr,
	output logic [DATA_W-1:0] x_ptr_upd,
	output logic [DATA_W-1:0] y_ptr_upd,
	output logic x_wrapped,
	output logic y_wrapped,
	// Literal and status results
	output logic [DATA_W-1:0] branch_offset,
	output logic [DATA_W-1:0] hold_count,
	output logic mod_reserved_warn,
	output logic [1:0] state_code
);
	agu_state_type state;
	agu_state_type next_state;
	ea_mode_type s_mode;
	ea_mode_type d_mode;
	pf_mode_type xm;
	pf_mode_type ym;

	// ==========================================================
	// Move and accumulator effective address
	// ==========================================================
	logic [DATA_W-1:0] lit_ext;
	logic [DATA_W-1:0] offset_ext;
	logic [DATA_W-1:0] next_src_ea;
	logic [DATA_W-1:0] next_dst_ea;
	logic [DATA_W-1:0] next_src_upd;
	logic [DATA_W-1:0] next_dst_upd;

	assign s_mode = ea_mode_type'(src_mode);
	assign d_mode = ea_mode_type'(dst_mode);
	// Literal widths: 8-bit zero extended or full 16-bit [R3]
	assign lit_ext = lit_is_word ? literal_value : {8'h00, literal_value[LIT8_W-1:0]};
	// One offset register value feeds both computations [R2]
	assign offset_ext = offset_reg_val;

	// Address of one operand for a given mode
	function automatic logic [DATA_W-1:0] ea_of(ea_mode_type m, logic [DATA_W-1:0] p,
		logic [DATA_W-1:0] off, logic [DATA_W-1:0] lit);
		logic [DATA_W-1:0] r;
		r = p;
		unique case (m)
			MODE_DIRECT, MODE_INDIRECT, MODE_POST_INC, MODE_POST_DEC: r = p;
			MODE_PRE_INC: r = DATA_W'(p + STEP_2);
			MODE_PRE_DEC: r = DATA_W'(p - STEP_2);
			MODE_INDEXED: r = DATA_W'(p + off); // [R1]
			MODE_LIT_OFFSET: r = DATA_W'(p + lit); // [R3]
			MODE_LIT8, MODE_LIT16: r = lit; // [R3]
			default: r = p;
		endcase
		return r;
	endfunction

	// Pointer value after the access
	function automatic logic [DATA_W-1:0] upd_of(ea_mode_type m, logic [DATA_W-1:0] p);
		logic [DATA_W-1:0] r;
		r = p;
		unique case (m)
			MODE_POST_INC, MODE_PRE_INC: r = DATA_W'(p + STEP_2);
			MODE_POST_DEC, MODE_PRE_DEC: r = DATA_W'(p - STEP_2);
			default: r = p;
		endcase
		return r;
	endfunction

	// Both addresses use the same shared offset [R2]
	assign next_src_ea = ea_of(s_mode, src_ptr_val, offset_ext, lit_ext);
	assign next_dst_ea = ea_of(d_mode, dst_ptr_val, offset_ext, lit_ext);
	assign next_src_upd = upd_of(s_mode, src_ptr_val);
	assign next_dst_upd = upd_of(d_mode, dst_ptr_val);

	// ==========================================================
	// Multiply-accumulate prefetch
	// ==========================================================
	logic [REG_SEL_W-1:0] x_off;
	logic [REG_SEL_W-1:0] y_off;
	logic x_sel_ok;
	logic y_sel_ok;
	logic x_idx_ok;
	logic y_idx_ok;
	logic pf_err;
	logic [DATA_W-1:0] x_step;
	logic [DATA_W-1:0] y_step;
	logic [DATA_W-1:0] next_x_addr;
	logic [DATA_W-1:0] next_y_addr;
	logic [DATA_W-1:0] x_raw_upd;
	logic [DATA_W-1:0] y_raw_upd;
	logic [DATA_W-1:0] x_mod_upd;
	logic [DATA_W-1:0] y_mod_upd;
	logic x_wrap_w;
	logic y_wrap_w;

	assign xm = pf_mode_type'(x_pf_mode);
	assign ym = pf_mode_type'(y_pf_mode);
	assign x_off = REG_SEL_W'(x_sel - MAC_PTR_BASE);
	assign y_off = REG_SEL_W'(y_sel - MAC_PTR_BASE);
	// Only pointers eight/nine feed X and ten/eleven feed Y [R4] [R5]
	assign x_sel_ok = (x_off == {2'b00, SEL_X_A}) || (x_off == {2'b00, SEL_X_B});
	assign y_sel_ok = (y_off == {2'b00, SEL_Y_A}) || (y_off == {2'b00, SEL_Y_B});
	// Indexed prefetch only on pointer nine and pointer eleven [R7]
	assign x_idx_ok = (xm != PF_INDEXED) || (x_off == {2'b00, SEL_X_B});
	assign y_idx_ok = (ym != PF_INDEXED) || (y_off == {2'b00, SEL_Y_B});
	assign pf_err = !(x_sel_ok && y_sel_ok && x_idx_ok && y_idx_ok);

	// Post-modify amount by 2, 4 or 6 either way [R8]
	function automatic logic [DATA_W-1:0] step_of(pf_mode_type m);
		logic [DATA_W-1:0] r;
		r = ZERO_16;
		unique case (m)
			PF_INDIRECT, PF_INDEXED: r = ZERO_16;
			PF_POST_2: r = STEP_2;
			PF_POST_4: r = STEP_4;
			PF_POST_6: r = STEP_6;
			PF_POST_M2: r = DATA_W'(ZERO_16 - STEP_2);
			PF_POST_M4: r = DATA_W'(ZERO_16 - STEP_4);
			PF_POST_M6: r = DATA_W'(ZERO_16 - STEP_6);
		endcase
		return r;
	endfunction

	assign x_step = step_of(xm);
	assign y_step = step_of(ym);
	assign next_x_addr = (xm == PF_INDEXED) ? DATA_W'(x_ptr_val + x_index_val) : x_ptr_val; // [R7]
	assign next_y_addr = (ym == PF_INDEXED) ? DATA_W'(y_ptr_val + y_index_val) : y_ptr_val; // [R7]
	assign x_raw_upd = DATA_W'(x_ptr_val + x_step); // [R8]
	assign y_raw_upd = DATA_W'(y_ptr_val + y_step); // [R8]

	// ==========================================================
	// Circular buffers, one per space
	// ==========================================================
	logic x_mod_hit;
	logic y_mod_hit;
	logic reserved_use;

	// Modulo pointer only acts when it is the selected prefetch pointer, registers eight to eleven [R12]
	assign x_mod_hit = x_mod_en && (x_mod_reg == x_sel); // [R10] [R11]
	assign y_mod_hit = y_mod_en && (y_mod_reg == y_sel); // [R11]
	// Frame or stack pointer as modulo pointer raises a warning [R12]
	assign reserved_use = (x_mod_en && (x_mod_reg == FRAME_PTR_NUM || x_mod_reg == STACK_PTR_NUM))
		|| (y_mod_en && (y_mod_reg == FRAME_PTR_NUM || y_mod_reg == STACK_PTR_NUM));

	modulo_wrap #(.W(DATA_W)) x_wrap_unit (
		.enable(x_mod_hit),
		.bidir(x_mod_bidir),
		.start_addr(x_mod_start),
		.end_addr(x_mod_end),
		.old_ptr(x_ptr_val),
		.new_ptr(x_raw_upd),
		.wrapped_ptr(x_mod_upd),
		.wrapped(x_wrap_w)
	);

	modulo_wrap #(.W(DATA_W)) y_wrap_unit (
		.enable(y_mod_hit),
		.bidir(y_mod_bidir),
		.start_addr(y_mod_start),
		.end_addr(y_mod_end),
		.old_ptr(y_ptr_val),
		.new_ptr(y_raw_upd),
		.wrapped_ptr(y_mod_upd),
		.wrapped(y_wrap_w)
	);

	// ==========================================================
	// Literals of branch and interrupt hold
	// ==========================================================
	logic [DATA_W-1:0] next_branch;
	logic [DATA_W-1:0] next_hold;

	// Signed 16-bit branch literal, unsigned 14-bit hold count [R9]
	assign next_branch = instr_literal[BRANCH_LIT_W-1:0];
	assign next_hold = {2'b00, instr_literal[HOLD_LIT_W-1:0]};

	// ==========================================================
	// Issue state
	// ==========================================================
	assign next_state = (mov_valid || mac_valid) ? ST_BUSY : ST_IDLE;
	// Status code comes straight from the state register
	assign state_code = state;

	// State register
	always_ff @(posedge clk)
	begin
		if (!resetn)
			state <= ST_IDLE;
		else
			state <= next_state;
	end

	// Move outputs
	always_ff @(posedge clk)
	begin
		if (!resetn)
		begin
			mov_done <= 1'b0;
			src_ea <= ZERO_16;
			dst_ea <= ZERO_16;
			src_is_literal <= 1'b0;
			src_ptr_upd <= ZERO_16;
			dst_ptr_upd <= ZERO_16;
		end
		else
		begin
			mov_done <= mov_valid;
			if (mov_valid)
			begin
				src_ea <= next_src_ea; // [R1] [R2] [R3]
				dst_ea <= next_dst_ea; // [R2]
				src_is_literal <= (s_mode == MODE_LIT8) || (s_mode == MODE_LIT16);
				src_ptr_upd <= next_src_upd;
				dst_ptr_upd <= next_dst_upd;
			end
		end
	end

	// Prefetch outputs, refused requests leave pointers alone
	always_ff @(posedge clk)
	begin
		if (!resetn)
		begin
			mac_done <= 1'b0;
			mac_error <= 1'b0;
			x_rd_addr <= ZERO_16;
			y_rd_addr <= ZERO_16;
			x_ptr_upd <= ZERO_16;
			y_ptr_upd <= ZERO_16;
			x_wrapped <= 1'b0;
			y_wrapped <= 1'b0;
		end
		else
		begin
			mac_done <= mac_valid && !pf_err;
			mac_error <= mac_valid && pf_err; // [R4] [R7]
			x_wrapped <= mac_valid && !pf_err && x_wrap_w; // [R15]
			y_wrapped <= mac_valid && !pf_err && y_wrap_w; // [R15]
			if (mac_valid && !pf_err)
			begin
				x_rd_addr <= next_x_addr; // [R5]
				y_rd_addr <= next_y_addr; // [R5]
				x_ptr_upd <= x_mod_upd; // [R15]
				y_ptr_upd <= y_mod_upd; // [R15]
			end
		end
	end

	// Literal and status outputs
	always_ff @(posedge clk)
	begin
		if (!resetn)
		begin
			branch_offset <= ZERO_16;
			hold_count <= ZERO_16;
			mod_reserved_warn <= 1'b0;
		end
		else
		begin
			if (branch_instr)
				branch_offset <= next_branch; // [R9]
			if (interrupt_hold_instr)
				hold_count <= next_hold; // [R9]
			mod_reserved_warn <= reserved_use; // [R12]
		end
	end
endmodule

// >>> include/agu_pkg.sv
// Package of constants and types for the operand address generator
package agu_pkg;
	localparam int DATA_W = 16;
	localparam int OFFSET_W = 4;
	localparam int LIT8_W = 8;
	localparam int LIT16_W = 16;
	localparam int BRANCH_LIT_W = 16;
	localparam int HOLD_LIT_W = 14;
	localparam int REG_SEL_W = 4;
	localparam int MAC_SEL_W = 2;
	localparam int WREG_COUNT = 16;
	// Register numbers with fixed duties
	localparam logic [3:0] FRAME_PTR_NUM = 4'hE;
	localparam logic [3:0] STACK_PTR_NUM = 4'hF;
	localparam logic [3:0] MAC_PTR_BASE = 4'h8;
	// Prefetch pointer selectors (offset from register eight)
	localparam logic [1:0] SEL_X_A = 2'h0;
	localparam logic [1:0] SEL_X_B = 2'h1;
	localparam logic [1:0] SEL_Y_A = 2'h2;
	localparam logic [1:0] SEL_Y_B = 2'h3;
	// Post-modify amounts of the prefetch modes, a unit step and zero
	localparam logic [15:0] STEP_2 = 16'h0002;
	localparam logic [15:0] STEP_4 = 16'h0004;
	localparam logic [15:0] STEP_6 = 16'h0006;
	localparam logic [15:0] STEP_1 = 16'h0001;
	localparam logic [15:0] ZERO_16 = 16'h0000;

	// Addressing modes of move and accumulator instructions
	typedef enum logic [3:0] {
		MODE_DIRECT = 4'h0,
		MODE_INDIRECT = 4'h1,
		MODE_POST_INC = 4'h2,
		MODE_POST_DEC = 4'h3,
		MODE_PRE_INC = 4'h4,
		MODE_PRE_DEC = 4'h5,
		MODE_INDEXED = 4'h6,
		MODE_LIT_OFFSET = 4'h7,
		MODE_LIT8 = 4'h8,
		MODE_LIT16 = 4'h9
	} ea_mode_type;

	// Prefetch modes of multiply-accumulate instructions
	typedef enum logic [2:0] {
		PF_INDIRECT = 3'h0,
		PF_POST_2 = 3'h1,
		PF_POST_4 = 3'h2,
		PF_POST_6 = 3'h3,
		PF_INDEXED = 3'h4,
		PF_POST_M2 = 3'h5,
		PF_POST_M4 = 3'h6,
		PF_POST_M6 = 3'h7
	} pf_mode_type;

	// Issue state of the generator
	typedef enum logic [1:0] {
		ST_IDLE = 2'b01,
		ST_BUSY = 2'b10
	} agu_state_type;
endpackage

// >>> rtl/modulo_wrap.sv
// Circular buffer boundary check and pointer wrap for one address space
module modulo_wrap
	import agu_pkg::*;
#(
	parameter int W = DATA_W
)
(
	input wire logic enable,
	input wire logic bidir,
	input wire logic [W-1:0] start_addr,
	input wire logic [W-1:0] end_addr,
	input wire logic [W-1:0] old_ptr,
	input wire logic [W-1:0] new_ptr,
	output logic [W-1:0] wrapped_ptr,
	output logic wrapped
);
	logic [W-1:0] length;
	logic going_up;
	logic going_down;
	logic above;
	logic below;
	logic allow_up;
	logic allow_down;
	logic [W-1:0] up_ptr;
	logic [W-1:0] down_ptr;

	// Direction of the update and buffer span
	assign length = W'(end_addr - start_addr + W'(1));
	assign going_up = new_ptr > old_ptr;
	assign going_down = new_ptr < old_ptr;
	assign above = new_ptr > end_addr;
	assign below = new_ptr < start_addr;
	// Unidirectional buffers check both sides when start <= end and neither side otherwise [R13]
	// Bidirectional buffers check both sides [R14]
	assign allow_up = bidir || (start_addr <= end_addr);
	assign allow_down = bidir || (start_addr <= end_addr);
	// Wrap to the opposite boundary keeping the overshoot [R15]
	assign up_ptr = W'(new_ptr - length);
	assign down_ptr = W'(new_ptr + length);
	assign wrapped = enable && ((going_up && above && allow_up) || (going_down && below && allow_down));
	assign wrapped_ptr = !wrapped ? new_ptr : (going_up ? up_ptr : down_ptr);
endmodule

// >>> tb/agu_regfile_model.sv
// Register file model on the decoder side of the prefetch pointers
module agu_regfile_model
	import agu_pkg::*;
(
	input wire logic clk,
	input wire logic ld_en,
	input wire logic [3:0] ld_num,
	input wire logic [15:0] ld_val,
	input wire logic mac_valid,
	input wire logic mac_done,
	input wire logic [3:0] x_sel,
	input wire logic [3:0] y_sel,
	input wire logic [15:0] x_ptr_upd,
	input wire logic [15:0] y_ptr_upd,
	output logic [15:0] x_ptr_val,
	output logic [15:0] y_ptr_val,
	output logic [15:0] x_index_val,
	output logic [15:0] y_index_val
);
	timeunit 1ns;
	timeprecision 100ps;
	logic [15:0] wreg [16];
	logic [3:0] xs_q;
	logic [3:0] ys_q;
	// Contents follow the selectors; offsets live in registers four and five
	assign x_ptr_val = wreg[x_sel];
	assign y_ptr_val = wreg[y_sel];
	assign x_index_val = wreg[4'h4];
	assign y_index_val = wreg[4'h5];
	// Bench loads and write-back of modified pointers
	always @(posedge clk)
	begin
		if (mac_valid)
		begin
			xs_q <= x_sel;
			ys_q <= y_sel;
		end
		if (mac_done)
		begin
			wreg[xs_q] <= x_ptr_upd;
			wreg[ys_q] <= y_ptr_upd;
		end
		if (ld_en)
			wreg[ld_num] <= ld_val;
	end
endmodule

// >>> tb/operand_address_generation_properties.sv
// Port checker of the operand address generator
module agu_checker
	import agu_pkg::*;
(
	input wire logic clk,
	input wire logic resetn,
	input wire logic mov_valid,
	input wire logic [3:0] src_mode,
	input wire logic [DATA_W-1:0] literal_value,
	input wire logic lit_is_word,
	input wire logic mac_valid,
	input wire logic [REG_SEL_W-1:0] x_sel,
	input wire logic [REG_SEL_W-1:0] y_sel,
	input wire logic [2:0] x_pf_mode,
	input wire logic [2:0] y_pf_mode,
	input wire logic [DATA_W-1:0] x_ptr_val,
	input wire logic [DATA_W-1:0] y_ptr_val,
	input wire logic x_mod_en,
	input wire logic [REG_SEL_W-1:0] x_mod_reg,
	input wire logic [DATA_W-1:0] x_mod_start,
	input wire logic [DATA_W-1:0] x_mod_end,
	input wire logic interrupt_hold_instr,
	input wire logic [DATA_W-1:0] instr_literal,
	input wire logic mov_done,
	input wire logic [DATA_W-1:0] src_ea,
	input wire logic src_is_literal,
	input wire logic mac_done,
	input wire logic mac_error,
	input wire logic [DATA_W-1:0] x_rd_addr,
	input wire logic [DATA_W-1:0] y_rd_addr,
	input wire logic [DATA_W-1:0] x_ptr_upd,
	input wire logic x_wrapped,
	input wire logic [DATA_W-1:0] hold_count
);
	timeunit 1ns;
	timeprecision 100ps;
	logic sel_ok;
	logic idx_bad;
	logic mac_ok;
	default clocking cb @(posedge clk); endclocking
	default disable iff (!resetn);
	// Legal prefetch requests
	assign sel_ok = (x_sel == 4'h8 || x_sel == 4'h9) && (y_sel == 4'hA || y_sel == 4'hB);
	assign idx_bad = (x_pf_mode == PF_INDEXED && x_sel != 4'h9) || (y_pf_mode == PF_INDEXED && y_sel != 4'hB);
	assign mac_ok = mac_valid && sel_ok && !idx_bad;
	property p_mov_done;
		mov_valid |=> mov_done;
	endproperty
	a_mov_done: assert property (p_mov_done) else $error("move not answered");
	property p_refuse;
		mac_valid && !sel_ok |=> mac_error && !mac_done;
	endproperty
	a_refuse: assert property (p_refuse) else $error("bad pointer accepted");
	property p_route;
		mac_ok && x_pf_mode == PF_INDIRECT && y_pf_mode == PF_INDIRECT
			|=> mac_done && x_rd_addr == $past(x_ptr_val) && y_rd_addr == $past(y_ptr_val);
	endproperty
	a_route: assert property (p_route) else $error("prefetch routed wrong");
	property p_idx;
		mac_valid && idx_bad |=> mac_error;
	endproperty
	a_idx: assert property (p_idx) else $error("indexed prefetch accepted");
	property p_post;
		mac_ok && !x_mod_en && x_pf_mode == PF_POST_6 |=> x_ptr_upd == $past(x_ptr_val) + STEP_6;
	endproperty
	a_post: assert property (p_post) else $error("post modify wrong");
	property p_lit;
		mov_valid && src_mode == MODE_LIT8 && !lit_is_word
			|=> src_is_literal && src_ea == ($past(literal_value) & 16'h00FF);
	endproperty
	a_lit: assert property (p_lit) else $error("short literal wrong");
	property p_hold;
		interrupt_hold_instr |=> hold_count == ($past(instr_literal) & 16'h3FFF);
	endproperty
	a_hold: assert property (p_hold) else $error("hold literal wrong");
	property p_wrap;
		mac_ok && x_mod_en && x_mod_reg == x_sel && x_pf_mode == PF_POST_2 && x_ptr_val == x_mod_end
			|=> x_wrapped && x_ptr_upd == $past(x_mod_start) + STEP_1;
	endproperty
	a_wrap: assert property (p_wrap) else $error("upper wrap wrong");
endmodule
bind operand_address_generation agu_checker chk (.*);

// >>> tb/operand_address_generation_test.sv
// Self-checking bench of the operand address generator
module operand_address_generation_test
	import agu_pkg::*;
;
	timeunit 1ns;
	timeprecision 100ps;
	logic clk, resetn, mov_valid, lit_is_word, mac_valid, branch_instr, interrupt_hold_instr, ld_en;
	logic x_mod_en, y_mod_en, x_mod_bidir, y_mod_bidir, mov_done, src_is_literal, mac_done, mac_error;
	logic x_wrapped, y_wrapped, mod_reserved_warn;
	logic [1:0] state_code;
	logic [2:0] x_pf_mode, y_pf_mode;
	logic [3:0] src_mode, dst_mode, src_reg, dst_reg, shared_offset_field, x_sel, y_sel, x_mod_reg, y_mod_reg, ld_num;
	logic [15:0] literal_value, src_ptr_val, dst_ptr_val, offset_reg_val, x_ptr_val, y_ptr_val, x_index_val;
	logic [15:0] y_index_val, instr_literal, x_mod_start, x_mod_end, y_mod_start, y_mod_end, ld_val, src_ea, dst_ea;
	logic [15:0] src_ptr_upd, dst_ptr_upd, x_rd_addr, y_rd_addr, x_ptr_upd, y_ptr_upd, branch_offset, hold_count;
	logic [15:0] shadow [16];
	int miscompares, check_count;
	operand_address_generation uut (.*);
	agu_regfile_model model (.*);
	always #12.5 clk = ~clk;
	// Comparison and verdict
	task automatic check(string what, logic [15:0] exp, logic [15:0] got);
		check_count++;
		if (got !== exp)
		begin
			miscompares++;
			$display("Error %s expected %h seen %h", what, exp, got);
		end
	endtask
	task automatic close_out();
		$display("checks %0d mismatches %0d", check_count, miscompares);
		if (miscompares == 0 && check_count > 0)
			$display("verification passed");
		else
			$display("verification failed");
		$finish;
	endtask
	// Expected pointer after a prefetch, with circular wrap
	function automatic logic [15:0] step(logic [2:0] m, logic [15:0] p);
		case (m)
			PF_POST_2: return p + STEP_2;
			PF_POST_4: return p + STEP_4;
			PF_POST_6: return p + STEP_6;
			PF_POST_M2: return p - STEP_2;
			PF_POST_M4: return p - STEP_4;
			PF_POST_M6: return p - STEP_6;
			default: return p;
		endcase
	endfunction
	function automatic logic [15:0] wrap(logic [15:0] n, logic [15:0] s, logic [15:0] e);
		if (n > e)
			return n - (e - s + 16'h0001);
		if (n < s)
			return n + (e - s + 16'h0001);
		return n;
	endfunction
	// Expected move address
	function automatic logic [15:0] ea(logic [3:0] m, logic [15:0] p);
		logic [15:0] lit;
		lit = lit_is_word ? literal_value : {8'h00, literal_value[7:0]};
		case (m)
			MODE_PRE_INC: return p + STEP_2;
			MODE_PRE_DEC: return p - STEP_2;
			MODE_INDEXED: return p + offset_reg_val;
			MODE_LIT_OFFSET: return p + lit;
			MODE_LIT8, MODE_LIT16: return lit;
			default: return p;
		endcase
	endfunction
	// Expected pointer after a move access
	function automatic logic [15:0] upd(logic [3:0] m, logic [15:0] p);
		case (m)
			MODE_POST_INC, MODE_PRE_INC: return p + STEP_2;
			MODE_POST_DEC, MODE_PRE_DEC: return p - STEP_2;
			default: return p;
		endcase
	endfunction
	task automatic load(logic [3:0] n, logic [15:0] v);
		ld_num = n;
		ld_val = v;
		shadow[n] = v;
		ld_en = 1'b1;
		@(negedge clk);
		ld_en = 1'b0;
		@(negedge clk);
	endtask
	// One prefetch, checked in the answer cycle
	task automatic mac(logic [3:0] xs, logic [3:0] ys, logic [2:0] xm, logic [2:0] ym);
		logic bad;
		logic [15:0] rx, ry, ux, uy;
		bad = !(xs inside {4'h8, 4'h9}) || !(ys inside {4'hA, 4'hB});
		bad = bad || (xm == PF_INDEXED && xs != 4'h9) || (ym == PF_INDEXED && ys != 4'hB);
		rx = step(xm, shadow[xs]);
		ry = step(ym, shadow[ys]);
		ux = (x_mod_en && x_mod_reg == xs) ? wrap(rx, x_mod_start, x_mod_end) : rx;
		uy = (y_mod_en && y_mod_reg == ys) ? wrap(ry, y_mod_start, y_mod_end) : ry;
		x_sel = xs;
		y_sel = ys;
		x_pf_mode = xm;
		y_pf_mode = ym;
		mac_valid = 1'b1;
		@(negedge clk);
		mac_valid = 1'b0;
		check("mac_error", {15'h0, bad}, {15'h0, mac_error});
		if (!bad)
		begin
			check("x_rd_addr", shadow[xs] + ((xm == PF_INDEXED) ? shadow[4] : 16'h0), x_rd_addr);
			check("y_rd_addr", shadow[ys] + ((ym == PF_INDEXED) ? shadow[5] : 16'h0), y_rd_addr);
			check("x_ptr_upd", ux, x_ptr_upd);
			check("y_ptr_upd", uy, y_ptr_upd);
			check("wrapped", {14'h0, ux != rx, uy != ry}, {14'h0, x_wrapped, y_wrapped});
			shadow[xs] = ux;
			shadow[ys] = uy;
		end
		@(negedge clk);
	endtask
	// One move request, held high between back-to-back calls
	task automatic mov(logic [3:0] sm, logic [3:0] dm);
		src_mode = sm;
		dst_mode = dm;
		{src_ptr_val, dst_ptr_val, offset_reg_val, literal_value} = {$urandom, $urandom};
		{src_reg, dst_reg, shared_offset_field} = 12'($urandom);
		lit_is_word = (sm == MODE_LIT16) || (sm != MODE_LIT8 && 1'($urandom));
		mov_valid = 1'b1;
		@(negedge clk);
		check("mov_done", 16'h1, {15'h0, mov_done});
		check("src_is_literal", {15'h0, sm inside {MODE_LIT8, MODE_LIT16}}, {15'h0, src_is_literal});
		if (sm != MODE_DIRECT)
			check("src_ea", ea(sm, src_ptr_val), src_ea);
		if (!(dm inside {MODE_DIRECT, MODE_LIT8, MODE_LIT16}))
			check("dst_ea", ea(dm, dst_ptr_val), dst_ea);
		check("src_ptr_upd", upd(sm, src_ptr_val), src_ptr_upd);
		check("dst_ptr_upd", upd(dm, dst_ptr_val), dst_ptr_upd);
		check("state_code", 16'h2, {14'h0, state_code});
	endtask
	initial
	begin
		{clk, resetn, mov_valid, lit_is_word, mac_valid, branch_instr, interrupt_hold_instr, ld_en} = '0;
		{x_mod_en, y_mod_en, x_mod_bidir, y_mod_bidir, x_pf_mode, y_pf_mode, src_mode, dst_mode} = '0;
		{src_reg, dst_reg, shared_offset_field, x_sel, y_sel, x_mod_reg, y_mod_reg, ld_num} = '0;
		{literal_value, src_ptr_val, dst_ptr_val, offset_reg_val, instr_literal, ld_val} = '0;
		{x_mod_start, x_mod_end, y_mod_start, y_mod_end} = '0;
		void'($urandom(32'hA8BD));
		repeat (12) @(posedge clk);
		@(negedge clk);
		check("state_code", 16'h1, {14'h0, state_code});
		check("x_ptr_upd", 16'h0, x_ptr_upd);
		resetn = 1'b1;
		// Pointers in X space for eight and nine, Y space for ten and eleven
		for (int i = 0; i < 16; i++)
			load(4'(i), (i inside {8, 9}) ? 16'h0800 + 16'($urandom % 256) * 2 : 16'h1800 + 16'($urandom % 256) * 2);
		for (int i = 0; i < 60; i++)
			mac((i % 4 == 0) ? 4'($urandom) : 4'h8 + 4'(i % 2), (i % 5 == 0) ? 4'($urandom) : 4'hA + 4'($urandom % 2),
				3'($urandom), 3'($urandom));
		mac(4'h9, 4'hB, PF_INDIRECT, PF_INDIRECT);
		$display("test prefetch done");
		for (int i = 0; i < 16; i++)
			mov(4'(i), 4'(i));
		for (int i = 0; i < 30; i++)
			mov(4'($urandom), 4'($urandom));
		mov_valid = 1'b0;
		$display("test move done");
		{branch_instr, interrupt_hold_instr} = 2'b11;
		for (int i = 0; i < 12; i++)
		begin
			instr_literal = (i == 0) ? 16'hFFFF : (i == 1) ? 16'h8000 : 16'($urandom);
			@(negedge clk);
			check("branch_offset", instr_literal, branch_offset);
			check("hold_count", instr_literal & 16'h3FFF, hold_count);
			check("state_code", 16'h1, {14'h0, state_code});
		end
		{branch_instr, interrupt_hold_instr} = 2'b00;
		$display("test literal done");
		{x_mod_en, y_mod_en, x_mod_bidir, y_mod_bidir} = 4'hF;
		{x_mod_reg, y_mod_reg} = {4'h8, 4'hA};
		{x_mod_start, x_mod_end, y_mod_start, y_mod_end} = {16'h0900, 16'h090F, 16'h1900, 16'h191F};
		load(4'h8, 16'h090F);
		load(4'hA, 16'h1900);
		mac(4'h8, 4'hA, PF_POST_2, PF_POST_M4);
		for (int i = 0; i < 24; i++)
			mac(4'h8, 4'hA, (i % 3 == 0) ? PF_POST_M6 : PF_POST_6, (i % 2 == 0) ? PF_POST_4 : PF_POST_M2);
		x_mod_reg = FRAME_PTR_NUM;
		repeat (2) @(negedge clk);
		check("mod_reserved_warn", 16'h1, {15'h0, mod_reserved_warn});
		x_mod_reg = 4'h9;
		repeat (2) @(negedge clk);
		check("mod_reserved_warn", 16'h0, {15'h0, mod_reserved_warn});
		$display("test circular done");
		// Reset in mid-run clears the held results
		resetn = 1'b0;
		@(negedge clk);
		check("src_ea", 16'h0, src_ea);
		check("x_rd_addr", 16'h0, x_rd_addr);
		check("branch_offset", 16'h0, branch_offset);
		check("state_code", 16'h1, {14'h0, state_code});
		resetn = 1'b1;
		mac(4'h8, 4'hA, PF_INDIRECT, PF_INDIRECT);
		$display("test reset done");
		close_out();
	end
	// Watchdog well beyond the expected run length
	initial
	begin
		repeat (5000) @(posedge clk);
		miscompares++;
		close_out();
	end
endmodule
